// [hdl/cdr_pkg.sv]
// Constants and carrier types of the control and device_status register bank
package cdr_pkg;
	// Register addresses
	localparam logic [5:0] CDR_ADDR_NVM_CTRL = 6'h1c;
	localparam logic [5:0] CDR_ADDR_FS_CFG = 6'h1d;
	localparam logic [5:0] CDR_ADDR_STATUS = 6'h20;
	localparam logic [5:0] CDR_ADDR_BST_FAULT = 6'h36;
	localparam logic [5:0] CDR_ADDR_BST_LEVEL = 6'h37;
	localparam logic [5:0] CDR_ADDR_SUPPLY = 6'h3b;
	localparam logic [5:0] CDR_ADDR_DRV_TEMP = 6'h3c;
	// Memory access control fields
	localparam int CDR_NVM_IDX_LSB = 4;
	localparam int CDR_NVM_CMD_LSB = 0;
	localparam int CDR_NVM_ON_BIT = 3;
	localparam logic [3:0] CDR_CMD_ENABLE = 4'h8;
	localparam logic [3:0] CDR_CMD_READ = 4'h9;
	localparam logic [3:0] CDR_CMD_UNLOCK = 4'he;
	localparam logic [3:0] CDR_CMD_WRITE = 4'ha;
	// Fail-safe configuration fields
	localparam int CDR_FS_SWRST_BIT = 0;
	localparam int CDR_FS_GO_BIT = 1;
	localparam int CDR_FS_LEAVE_BIT = 2;
	localparam int CDR_FS_WDG_MODE_LSB = 3;
	localparam int CDR_FS_WDG_TO_LSB = 5;
	localparam int CDR_FS_FAILPIN_BIT = 9;
	// Device status fields
	localparam int CDR_ST_HARDRST_BIT = 0;
	localparam int CDR_ST_FSMODE_BIT = 1;
	localparam int CDR_ST_THWARN_BIT = 2;
	localparam int CDR_ST_THSHUT_BIT = 3;
	localparam int CDR_ST_FRAME_LSB = 4;
	localparam int CDR_ST_REJECT_BIT = 8;
	localparam int CDR_ST_SERR_BIT = 9;
	localparam int CDR_ST_NVMERR_BIT = 10;
	localparam int CDR_ST_TRIM_BIT = 11;
	// Converter fault fields
	localparam int CDR_BF_P1_ACT_BIT = 0;
	localparam int CDR_BF_P1_REG_LSB = 1;
	localparam int CDR_BF_P2_ACT_BIT = 3;
	localparam int CDR_BF_P2_REG_LSB = 4;
	localparam int CDR_BF_DRVUV_BIT = 9;
	localparam int CDR_BF_HWERR_BIT = 10;
	localparam int CDR_BF_FBFAIL_BIT = 11;
	localparam int CDR_BF_EXTCLK_BIT = 12;
	localparam int CDR_BF_OV_BIT = 13;
	localparam int CDR_BF_SKIP_BIT = 14;
	// Measurement fields
	localparam int CDR_MEAS_HI_LSB = 10;
	localparam int CDR_MEAS_LO_LSB = 0;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [5:0] addr;
		logic [20:0] wdata;
	} cdr_req_type;

	typedef struct packed {
		logic frame_done;
		logic frame_error;
		logic nvm_cmd_refused;
		logic data_write_refused;
	} cdr_serial_in_type;

	typedef struct packed {
		logic thermal_shutdown;
		logic thermal_warning_flag;
		logic boost_error_summary;
		logic nvm_write_failure;
		logic nvm_read_check_failure;
		logic trim_check_error;
		logic boost_skip_cycle;
		logic boost_overvoltage;
		logic boost_ext_clock_fail;
		logic boost_feedback_fail;
		logic boost_hw_error;
		logic drive_supply_undervoltage;
		logic [1:0] phase2_regulation_state;
		logic phase2_active;
		logic [1:0] phase1_regulation_state;
		logic phase1_active;
		logic hard_reset_event;
	} cdr_status_in_type;

	typedef struct packed {
		logic [8:0] boost_output_sample;
		logic [8:0] battery_supply_sample;
		logic [8:0] internal_supply_sample;
		logic [8:0] gate_drive_supply_sample;
		logic [8:0] die_temperature_sample;
	} cdr_meas_type;

	typedef struct packed {
		logic [3:0] nvm_index;
		logic [3:0] nvm_cmd;
		logic nvm_read_go;
		logic nvm_write_go;
		logic failsafe_mode_flag;
		logic [1:0] failsafe_watchdog_timeout_sel;
		logic [1:0] failsafe_watchdog_mode_sel;
		logic boost_fault_to_fail_pin;
	} cdr_ctrl_type;

	typedef struct packed {
		cdr_ctrl_type ctrl;
		logic failure_out;
		logic hard_reset_flag;
		logic thermal_shutdown_flag;
		logic reject_flag;
		logic serial_error_flag;
		logic boost_skip_cycle_flag;
		logic boost_overvoltage_flag;
		logic [3:0] serial_frame_counter;
		logic [20:0] rd_data;
		logic rd_valid;
	} cdr_state_type;

	// Reset values
	localparam cdr_ctrl_type CDR_CTRL_RST = '0;
	localparam logic CDR_HWR_RST = 1'b1;
	localparam cdr_state_type CDR_STATE_RST = '{ctrl: CDR_CTRL_RST,
		hard_reset_flag: CDR_HWR_RST, default: '0};
endpackage : cdr_pkg

// [hdl/cdr_regs.sv]
// Control and device_status register bank of the boost LED driver
`timescale 1ns/10ps
`default_nettype none
module cdr_regs
	import cdr_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic ce,
	input wire cdr_req_type req,
	input wire cdr_serial_in_type ser,
	input wire cdr_status_in_type sts,
	input wire cdr_meas_type meas,
	output var cdr_ctrl_type ctrl_out,
	output var logic failure_out,
	output var logic [20:0] rd_data,
	output var logic rd_valid
);
	cdr_state_type st_ff;
	cdr_state_type nxt_st;

	// Next state of the whole bank
	always_comb begin
		logic [20:0] rd_word;
		logic [3:0] new_cmd;
		rd_word = '0;
		new_cmd = req.wdata[CDR_NVM_CMD_LSB +: 4];
		nxt_st = st_ff;
		nxt_st.ctrl.nvm_read_go = 1'b0;
		nxt_st.ctrl.nvm_write_go = 1'b0;
		nxt_st.rd_valid = 1'b0;
		// Failure output follows the summary only when routed
		nxt_st.failure_out = st_ff.ctrl.boost_fault_to_fail_pin & sts.boost_error_summary;
		// Read multiplexer
		case (req.addr)
			CDR_ADDR_NVM_CTRL: begin
				rd_word[CDR_NVM_IDX_LSB +: 4] = st_ff.ctrl.nvm_index;
				rd_word[CDR_NVM_CMD_LSB +: 4] = st_ff.ctrl.nvm_cmd;
			end
			CDR_ADDR_FS_CFG: begin
				rd_word[CDR_FS_FAILPIN_BIT] = st_ff.ctrl.boost_fault_to_fail_pin;
				rd_word[CDR_FS_WDG_TO_LSB +: 2] = st_ff.ctrl.failsafe_watchdog_timeout_sel;
				rd_word[CDR_FS_WDG_MODE_LSB +: 2] = st_ff.ctrl.failsafe_watchdog_mode_sel;
			end
			CDR_ADDR_STATUS: begin
				rd_word[CDR_ST_TRIM_BIT] = sts.trim_check_error;
				rd_word[CDR_ST_NVMERR_BIT] = sts.nvm_write_failure | sts.nvm_read_check_failure;
				rd_word[CDR_ST_SERR_BIT] = st_ff.serial_error_flag;
				rd_word[CDR_ST_REJECT_BIT] = st_ff.reject_flag;
				rd_word[CDR_ST_FRAME_LSB +: 4] = st_ff.serial_frame_counter;
				rd_word[CDR_ST_THSHUT_BIT] = st_ff.thermal_shutdown_flag;
				rd_word[CDR_ST_THWARN_BIT] = sts.thermal_warning_flag;
				rd_word[CDR_ST_FSMODE_BIT] = st_ff.ctrl.failsafe_mode_flag;
				rd_word[CDR_ST_HARDRST_BIT] = st_ff.hard_reset_flag;
			end
			CDR_ADDR_BST_FAULT: begin
				rd_word[CDR_BF_SKIP_BIT] = st_ff.boost_skip_cycle_flag;
				rd_word[CDR_BF_OV_BIT] = st_ff.boost_overvoltage_flag;
				rd_word[CDR_BF_EXTCLK_BIT] = sts.boost_ext_clock_fail;
				rd_word[CDR_BF_FBFAIL_BIT] = sts.boost_feedback_fail;
				rd_word[CDR_BF_HWERR_BIT] = sts.boost_hw_error;
				rd_word[CDR_BF_DRVUV_BIT] = sts.drive_supply_undervoltage;
				rd_word[CDR_BF_P2_REG_LSB +: 2] = sts.phase2_regulation_state;
				rd_word[CDR_BF_P2_ACT_BIT] = sts.phase2_active;
				rd_word[CDR_BF_P1_REG_LSB +: 2] = sts.phase1_regulation_state;
				rd_word[CDR_BF_P1_ACT_BIT] = sts.phase1_active;
			end
			CDR_ADDR_BST_LEVEL: begin
				rd_word[CDR_MEAS_LO_LSB +: 9] = meas.boost_output_sample;
			end
			CDR_ADDR_SUPPLY: begin
				rd_word[CDR_MEAS_HI_LSB +: 9] = meas.battery_supply_sample;
				rd_word[CDR_MEAS_LO_LSB +: 9] = meas.internal_supply_sample;
			end
			CDR_ADDR_DRV_TEMP: begin
				rd_word[CDR_MEAS_HI_LSB +: 9] = meas.gate_drive_supply_sample;
				rd_word[CDR_MEAS_LO_LSB +: 9] = meas.die_temperature_sample;
			end
			default: begin
				rd_word = '0;
			end
		endcase
		// Read answer and clear-on-read of latched flags
		if (req.rd) begin
			nxt_st.rd_valid = 1'b1;
			nxt_st.rd_data = rd_word;
			if (req.addr == CDR_ADDR_STATUS) begin
				nxt_st.hard_reset_flag = 1'b0;
				nxt_st.thermal_shutdown_flag = 1'b0;
				nxt_st.reject_flag = 1'b0;
				nxt_st.serial_error_flag = 1'b0;
			end
			if (req.addr == CDR_ADDR_BST_FAULT) begin
				nxt_st.boost_skip_cycle_flag = 1'b0;
				nxt_st.boost_overvoltage_flag = 1'b0;
			end
		end
		// Register writes
		if (req.wr) begin
			case (req.addr)
				CDR_ADDR_NVM_CTRL: begin
					if (st_ff.ctrl.failsafe_mode_flag) begin
						nxt_st.reject_flag = 1'b1;
					end else if (new_cmd == CDR_CMD_WRITE && st_ff.ctrl.nvm_cmd != CDR_CMD_UNLOCK) begin
						nxt_st.reject_flag = 1'b1;
					end else begin
						nxt_st.ctrl.nvm_index = req.wdata[CDR_NVM_IDX_LSB +: 4];
						nxt_st.ctrl.nvm_cmd = new_cmd;
						nxt_st.ctrl.nvm_read_go = (new_cmd == CDR_CMD_READ);
						nxt_st.ctrl.nvm_write_go = (new_cmd == CDR_CMD_WRITE);
					end
				end
				CDR_ADDR_FS_CFG: begin
					if (req.wdata[CDR_FS_SWRST_BIT]) begin
						nxt_st.ctrl = CDR_CTRL_RST;
					end else begin
						nxt_st.ctrl.boost_fault_to_fail_pin = req.wdata[CDR_FS_FAILPIN_BIT];
						nxt_st.ctrl.failsafe_watchdog_timeout_sel =
							req.wdata[CDR_FS_WDG_TO_LSB +: 2];
						nxt_st.ctrl.failsafe_watchdog_mode_sel =
							req.wdata[CDR_FS_WDG_MODE_LSB +: 2];
						if (req.wdata[CDR_FS_LEAVE_BIT]) begin
							nxt_st.ctrl.failsafe_mode_flag = 1'b0;
						end
						if (req.wdata[CDR_FS_GO_BIT]) begin
							nxt_st.ctrl.failsafe_mode_flag = 1'b1;
						end
					end
				end
				default: begin
					nxt_st.ctrl = nxt_st.ctrl;
				end
			endcase
		end
		// Frame counter wraps at sixteen
		if (ser.frame_done) begin
			nxt_st.serial_frame_counter = st_ff.serial_frame_counter + 4'h1;
		end
		// Hardware events last, so a set beats a clear in the same cycle
		if (ser.frame_error) begin
			nxt_st.serial_error_flag = 1'b1;
		end
		if (ser.nvm_cmd_refused || ser.data_write_refused) begin
			nxt_st.reject_flag = 1'b1;
		end
		if (sts.thermal_shutdown) begin
			nxt_st.thermal_shutdown_flag = 1'b1;
		end
		if (sts.hard_reset_event) begin
			nxt_st.hard_reset_flag = 1'b1;
		end
		if (sts.boost_skip_cycle) begin
			nxt_st.boost_skip_cycle_flag = 1'b1;
		end
		if (sts.boost_overvoltage) begin
			nxt_st.boost_overvoltage_flag = 1'b1;
		end
	end

	// State register, frozen while the clock enable is low
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			st_ff <= CDR_STATE_RST;
		end else if (ce) begin
			st_ff <= nxt_st;
		end
	end

	// Outputs straight from the state register
	assign ctrl_out = st_ff.ctrl;
	assign failure_out = st_ff.failure_out;
	assign rd_data = st_ff.rd_data;
	assign rd_valid = st_ff.rd_valid;

	// Checks on the register bank
	property p_nvm_fields;
		@(posedge sys_clk) disable iff (!nrst)
		(ce && req.wr && req.addr == CDR_ADDR_NVM_CTRL && !st_ff.ctrl.failsafe_mode_flag
			&& req.wdata[3:0] != CDR_CMD_WRITE)
		|=> (ctrl_out.nvm_index == $past(req.wdata[7:4])) && (ctrl_out.nvm_cmd == $past(req.wdata[3:0]));
	endproperty
	a_nvm_fields: assert property (p_nvm_fields) else $error("index or command not stored");

	property p_read_go;
		@(posedge sys_clk) disable iff (!nrst)
		(ce && req.wr && req.addr == CDR_ADDR_NVM_CTRL && !st_ff.ctrl.failsafe_mode_flag
			&& req.wdata[3:0] == CDR_CMD_READ)
		|=> ctrl_out.nvm_read_go && !ctrl_out.nvm_write_go;
	endproperty
	a_read_go: assert property (p_read_go) else $error("read command not issued");

	property p_write_locked;
		@(posedge sys_clk) disable iff (!nrst)
		(ce && req.wr && req.addr == CDR_ADDR_NVM_CTRL && req.wdata[3:0] == CDR_CMD_WRITE
			&& ctrl_out.nvm_cmd != CDR_CMD_UNLOCK)
		|=> !ctrl_out.nvm_write_go && st_ff.reject_flag;
	endproperty
	a_write_locked: assert property (p_write_locked) else $error("locked write not rejected");

	property p_fs_go;
		@(posedge sys_clk) disable iff (!nrst)
		(ce && req.wr && req.addr == CDR_ADDR_FS_CFG && req.wdata[1:0] == 2'h2)
		|=> ctrl_out.failsafe_mode_flag;
	endproperty
	a_fs_go: assert property (p_fs_go) else $error("fail-safe not entered");

	property p_fs_leave;
		@(posedge sys_clk) disable iff (!nrst)
		(ce && req.wr && req.addr == CDR_ADDR_FS_CFG && req.wdata[2:0] == 3'h4)
		|=> !ctrl_out.failsafe_mode_flag;
	endproperty
	a_fs_leave: assert property (p_fs_leave) else $error("fail-safe not left");

	property p_wdg_sel;
		@(posedge sys_clk) disable iff (!nrst)
		(ce && req.wr && req.addr == CDR_ADDR_FS_CFG && !req.wdata[0])
		|=> ctrl_out.failsafe_watchdog_timeout_sel == $past(req.wdata[6:5])
			&& ctrl_out.failsafe_watchdog_mode_sel == $past(req.wdata[4:3]);
	endproperty
	a_wdg_sel: assert property (p_wdg_sel) else $error("watchdog selects wrong");

	property p_fail_pin;
		@(posedge sys_clk) disable iff (!nrst)
		(ce && !ctrl_out.boost_fault_to_fail_pin) |=> !failure_out;
	endproperty
	a_fail_pin: assert property (p_fail_pin) else $error("failure output not gated");

	property p_status_word;
		@(posedge sys_clk) disable iff (!nrst)
		(ce && req.rd && req.addr == CDR_ADDR_STATUS)
		|=> rd_valid && rd_data[10] == $past(sts.nvm_write_failure | sts.nvm_read_check_failure)
			&& rd_data[11] == $past(sts.trim_check_error)
			&& rd_data[7:4] == $past(st_ff.serial_frame_counter);
	endproperty
	a_status_word: assert property (p_status_word) else $error("status word wrong");

	property p_serr_set;
		@(posedge sys_clk) disable iff (!nrst)
		(ce && ser.frame_error) |=> st_ff.serial_error_flag;
	endproperty
	a_serr_set: assert property (p_serr_set) else $error("serial error lost");

	property p_flag_hold;
		@(posedge sys_clk) disable iff (!nrst)
		(st_ff.thermal_shutdown_flag && !(ce && req.rd && req.addr == CDR_ADDR_STATUS))
		|=> st_ff.thermal_shutdown_flag;
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("latched flag dropped");

	property p_frames;
		@(posedge sys_clk) disable iff (!nrst)
		(ce && ser.frame_done)
		|=> st_ff.serial_frame_counter == $past(st_ff.serial_frame_counter) + 4'h1;
	endproperty
	a_frames: assert property (p_frames) else $error("frame count wrong");

	property p_fault_word;
		@(posedge sys_clk) disable iff (!nrst)
		(ce && req.rd && req.addr == CDR_ADDR_BST_FAULT)
		|=> rd_data[5:3] == $past({sts.phase2_regulation_state, sts.phase2_active})
			&& rd_data[2:0] == $past({sts.phase1_regulation_state, sts.phase1_active})
			&& rd_data[12] == $past(sts.boost_ext_clock_fail);
	endproperty
	a_fault_word: assert property (p_fault_word) else $error("fault word wrong");

	property p_meas_word;
		@(posedge sys_clk) disable iff (!nrst)
		(ce && req.rd && req.addr == CDR_ADDR_SUPPLY)
		|=> rd_data[18:10] == $past(meas.battery_supply_sample)
			&& rd_data[8:0] == $past(meas.internal_supply_sample) && rd_data[9] == 1'b0;
	endproperty
	a_meas_word: assert property (p_meas_word) else $error("supply word wrong");

	property p_soft_reset;
		@(posedge sys_clk) disable iff (!nrst)
		(ce && req.wr && req.addr == CDR_ADDR_FS_CFG && req.wdata[0]) |=> ctrl_out == CDR_CTRL_RST;
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("soft reset incomplete");

	property p_freeze;
		@(posedge sys_clk) disable iff (!nrst)
		(!ce && nrst) |=> st_ff == $past(st_ff);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while clock enable low");

	property p_write_go;
		@(posedge sys_clk) disable iff (!nrst)
		(ce && req.wr && req.addr == CDR_ADDR_NVM_CTRL && !ctrl_out.failsafe_mode_flag
			&& req.wdata[3:0] == CDR_CMD_WRITE && ctrl_out.nvm_cmd == CDR_CMD_UNLOCK)
		|=> ctrl_out.nvm_write_go && !ctrl_out.nvm_read_go && ctrl_out.nvm_cmd == CDR_CMD_WRITE;
	endproperty
	a_write_go: assert property (p_write_go) else $error("unlocked write not issued");

	property p_go_pulse;
		@(posedge sys_clk) disable iff (!nrst)
		(ce && !req.wr && (ctrl_out.nvm_read_go || ctrl_out.nvm_write_go))
		|=> !ctrl_out.nvm_read_go && !ctrl_out.nvm_write_go;
	endproperty
	a_go_pulse: assert property (p_go_pulse) else $error("memory strobe stretched");

	property p_fs_protect;
		@(posedge sys_clk) disable iff (!nrst)
		(ce && req.wr && req.addr == CDR_ADDR_NVM_CTRL && ctrl_out.failsafe_mode_flag)
		|=> st_ff.reject_flag && $stable(ctrl_out.nvm_cmd) && !ctrl_out.nvm_read_go;
	endproperty
	a_fs_protect: assert property (p_fs_protect) else $error("protected write taken");

	property p_refused_latch;
		@(posedge sys_clk) disable iff (!nrst)
		(ce && (ser.nvm_cmd_refused || ser.data_write_refused)) |=> st_ff.reject_flag;
	endproperty
	a_refused_latch: assert property (p_refused_latch) else $error("refusal not latched");

	property p_event_latch;
		@(posedge sys_clk) disable iff (!nrst)
		ce |=> (!$past(sts.thermal_shutdown) || st_ff.thermal_shutdown_flag)
			&& (!$past(sts.hard_reset_event) || st_ff.hard_reset_flag)
			&& (!$past(sts.boost_skip_cycle) || st_ff.boost_skip_cycle_flag)
			&& (!$past(sts.boost_overvoltage) || st_ff.boost_overvoltage_flag);
	endproperty
	a_event_latch: assert property (p_event_latch) else $error("event not latched");

	property p_level_word;
		@(posedge sys_clk) disable iff (!nrst)
		(ce && req.rd && req.addr == CDR_ADDR_BST_LEVEL)
		|=> rd_valid && rd_data == {12'h0, $past(meas.boost_output_sample)};
	endproperty
	a_level_word: assert property (p_level_word) else $error("boost level word wrong");

	property p_drive_word;
		@(posedge sys_clk) disable iff (!nrst)
		(ce && req.rd && req.addr == CDR_ADDR_DRV_TEMP)
		|=> rd_data == {2'h0, $past(meas.gate_drive_supply_sample), 1'h0,
			$past(meas.die_temperature_sample)};
	endproperty
	a_drive_word: assert property (p_drive_word) else $error("drive word wrong");

	property p_status_flags;
		@(posedge sys_clk) disable iff (!nrst)
		(ce && req.rd && req.addr == CDR_ADDR_STATUS)
		|=> rd_data[9:8] == $past({st_ff.serial_error_flag, st_ff.reject_flag})
			&& rd_data[3] == $past(st_ff.thermal_shutdown_flag)
			&& rd_data[0] == $past(st_ff.hard_reset_flag) && rd_data[20:12] == 9'h0;
	endproperty
	a_status_flags: assert property (p_status_flags) else $error("status flags wrong");

	property p_read_clear;
		@(posedge sys_clk) disable iff (!nrst)
		(ce && req.rd && req.addr == CDR_ADDR_STATUS && !ser.frame_error)
		|=> !st_ff.serial_error_flag;
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("flag kept after read");

	property p_fail_route;
		@(posedge sys_clk) disable iff (!nrst)
		(ce && ctrl_out.boost_fault_to_fail_pin) |=> failure_out == $past(sts.boost_error_summary);
	endproperty
	a_fail_route: assert property (p_fail_route) else $error("boost error not routed");

	// Main scenarios
	c_unlock_write: cover property (@(posedge sys_clk) disable iff (!nrst) ctrl_out.nvm_write_go);
	c_fs_enter: cover property (@(posedge sys_clk) disable iff (!nrst)
		!ctrl_out.failsafe_mode_flag ##1 ctrl_out.failsafe_mode_flag);
	c_status_read: cover property (@(posedge sys_clk) disable iff (!nrst) rd_valid && rd_data[9]);
	c_fail_out: cover property (@(posedge sys_clk) disable iff (!nrst) failure_out);
endmodule : cdr_regs
`default_nettype wire

// [testbench/cdr_host.sv]
// Host-side bus master model that drives the register bank requests
`timescale 1ns/10ps
`default_nettype none
module cdr_host
	import cdr_pkg::*;
(
	input wire logic sys_clk,
	output var cdr_req_type req,
	input wire logic rd_valid,
	input wire logic [20:0] rd_data
);
	initial begin
		req = '0;
	end

	// Write strobe for one edge; released fields show the inverse of their last value
	task automatic write_reg(input logic [5:0] a, input logic [20:0] d);
		@(posedge sys_clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge sys_clk);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
		#1;
	endtask : write_reg

	// Read strobe for one edge, then a bounded wait for the answer
	task automatic read_reg(input logic [5:0] a, output logic [20:0] d);
		int n;
		@(posedge sys_clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 21'h0};
		@(posedge sys_clk);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 21'h1fffff};
		#1;
		n = 0;
		while (rd_valid !== 1'b1 && n < 4) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		d = (rd_valid === 1'b1) ? rd_data : 'x;
	endtask : read_reg
endmodule : cdr_host
`default_nettype wire

// [testbench/cdr_regs_bench.sv]
// Self-checking bench of the control and device_status register bank
`timescale 1ns/10ps
`default_nettype none
module cdr_regs_bench;
	import cdr_pkg::*;
	logic sys_clk;
	logic nrst;
	logic ce;
	cdr_req_type req;
	cdr_serial_in_type ser;
	cdr_status_in_type sts;
	cdr_meas_type meas;
	cdr_ctrl_type ctrl_out;
	logic failure_out;
	logic [20:0] rd_data;
	logic rd_valid;
	int error_cnt = 0;
	int checks_done = 0;

	cdr_regs dut (.sys_clk(sys_clk), .nrst(nrst), .ce(ce), .req(req), .ser(ser), .sts(sts),
		.meas(meas), .ctrl_out(ctrl_out), .failure_out(failure_out), .rd_data(rd_data),
		.rd_valid(rd_valid));
	cdr_host host (.sys_clk(sys_clk), .req(req), .rd_valid(rd_valid), .rd_data(rd_data));

	// 40 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	task automatic stop_test();
		if (error_cnt == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : stop_test

	task automatic chk(input string what, input logic [20:0] exp, input logic [20:0] got);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Read one register and compare the word
	task automatic rd_chk(input logic [5:0] a, input logic [20:0] exp);
		logic [20:0] d;
		host.read_reg(a, d);
		chk($sformatf("reg_%h", a), exp, d);
	endtask : rd_chk

	// One-cycle pulse on the serial event inputs
	task automatic pulse(input cdr_serial_in_type v);
		@(posedge sys_clk);
		ser <= v;
		@(posedge sys_clk);
		ser <= '0;
	endtask : pulse

	// Reset values, one-shot hard reset flag, unmapped read
	task automatic t_reset();
		chk("ctrl_out", 21'h0, 21'(ctrl_out));
		rd_chk(CDR_ADDR_STATUS, 21'h000001);
		rd_chk(CDR_ADDR_STATUS, 21'h000000);
		rd_chk(6'h00, 21'h000000);
	endtask : t_reset

	// Every command code, unlock then write, write without unlock
	task automatic t_nvm();
		logic [3:0] cmds [4] = '{4'h0, 4'h8, 4'h9, 4'he};
		for (int i = 0; i < 4; i++) begin
			host.write_reg(CDR_ADDR_NVM_CTRL, {13'h0, 4'(i + 3), cmds[i]});
			chk("read_go", {20'h0, cmds[i] == 4'h9}, {20'h0, ctrl_out.nvm_read_go});
			chk("nvm_ctrl", {13'h0, 4'(i + 3), cmds[i]}, {13'h0, ctrl_out.nvm_index,
				ctrl_out.nvm_cmd});
			rd_chk(CDR_ADDR_NVM_CTRL, {13'h0, 4'(i + 3), cmds[i]});
		end
		host.write_reg(CDR_ADDR_NVM_CTRL, 21'h0000ca);
		chk("write_go", 21'h1, {20'h0, ctrl_out.nvm_write_go});
		@(posedge sys_clk);
		#1;
		chk("write_go_end", 21'h0, {20'h0, ctrl_out.nvm_write_go});
		host.write_reg(CDR_ADDR_NVM_CTRL, 21'h00003a);
		chk("write_go_refused", 21'h0, {20'h0, ctrl_out.nvm_write_go});
		rd_chk(CDR_ADDR_NVM_CTRL, 21'h0000ca);
		rd_chk(CDR_ADDR_STATUS, 21'h000100);
	endtask : t_nvm

	// Fail-safe entry, protection, fail pin routing, exit, soft reset
	task automatic t_fs();
		host.write_reg(CDR_ADDR_FS_CFG, 21'h000232);
		chk("fs_ctrl", 21'h2d, {15'h0, ctrl_out.failsafe_mode_flag,
			ctrl_out.failsafe_watchdog_timeout_sel, ctrl_out.failsafe_watchdog_mode_sel,
			ctrl_out.boost_fault_to_fail_pin});
		rd_chk(CDR_ADDR_FS_CFG, 21'h000230);
		host.write_reg(CDR_ADDR_NVM_CTRL, 21'h000008);
		rd_chk(CDR_ADDR_NVM_CTRL, 21'h0000ca);
		rd_chk(CDR_ADDR_STATUS, 21'h000102);
		@(posedge sys_clk);
		sts.boost_error_summary <= 1'b1;
		@(posedge sys_clk);
		#1;
		chk("failure_out", 21'h1, {20'h0, failure_out});
		host.write_reg(CDR_ADDR_FS_CFG, 21'h000234);
		chk("fs_flag", 21'h0, {20'h0, ctrl_out.failsafe_mode_flag});
		rd_chk(CDR_ADDR_STATUS, 21'h000000);
		host.write_reg(CDR_ADDR_FS_CFG, 21'h000001);
		chk("ctrl_soft_reset", 21'h0, 21'(ctrl_out));
		@(posedge sys_clk);
		#1;
		chk("failure_out_off", 21'h0, {20'h0, failure_out});
		sts.boost_error_summary <= 1'b0;
	endtask : t_fs

	// Frame counter wrap and latched serial and thermal flags
	task automatic t_events();
		repeat (17) pulse('{frame_done: 1'b1, default: 1'b0});
		pulse('{frame_error: 1'b1, nvm_cmd_refused: 1'b1, default: 1'b0});
		@(posedge sys_clk);
		sts.thermal_shutdown <= 1'b1;
		@(posedge sys_clk);
		sts.thermal_shutdown <= 1'b0;
		rd_chk(CDR_ADDR_STATUS, 21'h000318);
		rd_chk(CDR_ADDR_STATUS, 21'h000010);
		pulse('{data_write_refused: 1'b1, default: 1'b0});
		rd_chk(CDR_ADDR_STATUS, 21'h000110);
	endtask : t_events

	// Live status, converter faults and measurements
	task automatic t_live();
		@(posedge sys_clk);
		sts.trim_check_error <= 1'b1;
		sts.nvm_write_failure <= 1'b1;
		rd_chk(CDR_ADDR_STATUS, 21'h000c10);
		sts.trim_check_error <= 1'b0;
		sts.nvm_write_failure <= 1'b0;
		sts.nvm_read_check_failure <= 1'b1;
		rd_chk(CDR_ADDR_STATUS, 21'h000410);
		sts.nvm_read_check_failure <= 1'b0;
		sts.boost_skip_cycle <= 1'b1;
		sts.boost_overvoltage <= 1'b1;
		sts.boost_ext_clock_fail <= 1'b1;
		sts.phase2_regulation_state <= 2'h2;
		sts.phase2_active <= 1'b1;
		sts.phase1_regulation_state <= 2'h1;
		@(posedge sys_clk);
		sts.boost_skip_cycle <= 1'b0;
		sts.boost_overvoltage <= 1'b0;
		rd_chk(CDR_ADDR_BST_FAULT, 21'h00702a);
		rd_chk(CDR_ADDR_BST_FAULT, 21'h00102a);
		sts.phase2_regulation_state <= 2'h1;
		sts.phase2_active <= 1'b0;
		sts.phase1_regulation_state <= 2'h2;
		sts.phase1_active <= 1'b1;
		rd_chk(CDR_ADDR_BST_FAULT, 21'h001015);
		meas <= '{9'h1a5, 9'h0c3, 9'h15a, 9'h0f0, 9'h10f};
		rd_chk(CDR_ADDR_BST_LEVEL, 21'h0001a5);
		rd_chk(CDR_ADDR_SUPPLY, {2'h0, 9'h0c3, 1'b0, 9'h15a});
		rd_chk(CDR_ADDR_DRV_TEMP, {2'h0, 9'h0f0, 1'b0, 9'h10f});
		host.write_reg(CDR_ADDR_BST_LEVEL, 21'h1fffff);
		rd_chk(CDR_ADDR_BST_LEVEL, 21'h0001a5);
	endtask : t_live

	// Clock enable low: a write and a frame are lost, state stays frozen
	task automatic t_freeze();
		@(posedge sys_clk);
		ce <= 1'h0;
		host.write_reg(CDR_ADDR_FS_CFG, 21'h000060);
		pulse('{frame_done: 1'h1, default: 1'h0});
		chk("frozen_wdg", 21'h0, {19'h0, ctrl_out.failsafe_watchdog_timeout_sel});
		@(posedge sys_clk);
		ce <= 1'h1;
		rd_chk(CDR_ADDR_STATUS, 21'h000010);
		rd_chk(CDR_ADDR_FS_CFG, 21'h000000);
	endtask : t_freeze

	// Reset, then the scenarios in turn
	initial begin
		nrst = 1'b0;
		ce = 1'b1;
		ser = '0;
		sts = '0;
		meas = '0;
		repeat (5) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		#1;
		t_reset();
		t_nvm();
		t_fs();
		t_events();
		t_live();
		t_freeze();
		stop_test();
	end

	// Hang guard, well beyond the roughly 135 cycles the scenarios need
	initial begin
		#200us;
		error_cnt++;
		stop_test();
	end
endmodule : cdr_regs_bench
`default_nettype wire
